/* File: core/ocr_bank_decode.sv */
// Purpose: split one 128-bit bank into its parameter fields
// Assumes: layout from the package
// Notes: purely combinational
`timescale 1ns/1ps
module ocr_bank_decode import ocr_pkg::*; (
  input wire logic [BANK_BITS-1:0] bank_in,
  output logic [STA_W-1:0] sta_out,
  output logic [ADC_W-1:0] adc_out,
  output logic [XTL_W-1:0] xtl_out,
  output logic [QG_W-1:0] qg_out,
  output logic [QP_W-1:0] qp_out,
  output logic [SW_W-1:0] sw_out,
  output logic [FV_W-1:0] valid_out,
  output logic ok_out
);
  // whole bank gate
  assign ok_out = ocr_bank_good(bank_in);
  // raw fields
  assign sta_out = bank_in[STA_LSB +: STA_W];
  assign adc_out = bank_in[ADC_LSB +: ADC_W];
  assign xtl_out = bank_in[XTL_LSB +: XTL_W];
  assign qg_out = bank_in[QG_LSB +: QG_W];
  assign qp_out = bank_in[QP_LSB +: QP_W];
  assign sw_out = bank_in[SW_LSB +: SW_W];
  // each field's own flag, masked by the bank gate
  assign valid_out = {bank_in[QP_VLD], bank_in[QG_VLD], bank_in[XTL_VLD],
                      bank_in[ADC_VLD], bank_in[STA_VLD]} & {FV_W{ok_out}};
endmodule

/* File: core/ocr_fuse_mem.sv */
// Purpose: one-time-programmable fuse array model
// Assumes: blank fuses read zero
// Notes: content is not touched by reset
`timescale 1ns/1ps
module ocr_fuse_mem import ocr_pkg::*; #(
  parameter int WORDS = FUSE_WORDS,
  parameter int WIDTH = WORD_BITS
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  ocr_fuse_if.mem fuse
);
  if (WORDS * WIDTH != FUSE_BITS) begin : g_bad_size
    $error("fuse geometry must hold the whole store");
  end

  // blank array at power up; the write process below stays its only writer
  logic [WIDTH-1:0] cells [WORDS] = '{default: '0};

  // burning can only set bits, so each word stays independent
  always_ff @(posedge mclk_in) begin
    if (fuse.wr_en && fuse.addr < WORDS) begin
      cells[fuse.addr] <= cells[fuse.addr] | fuse.wdata;
    end
  end

  // registered read port
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      fuse.rdata <= '0;
    end else if (fuse.rd_en) begin
      fuse.rdata <= (fuse.addr < WORDS) ? cells[fuse.addr] : '0;
    end
  end
endmodule

/* File: core/ocr_reader.sv */
// Purpose: scan the fuse banks after reset and publish parameters
// Assumes: register port strobes are one cycle, never both at once
// Notes: scan takes 50 cycles; burns need a rescan to take effect
// Operation
// - 768-bit fuse store becomes readable after reset is released.
// - Six banks of 128 bits, all with the same field layout.
// - Low 108 bits are fixed fields; top 20 bits are software bits.
// - Short-range radio address equals station address plus one.
// - Each bank programs independently, allowing later updates.
// - A bank with its invalid flag set supplies no fields.
// - Only a bank with its used flag set supplies parameters.
// - Every field has its own flag: 0 invalid, 1 usable.
// - Bank zero carries factory trims and optional station address.
// - Quadrature trims load only when both flags are 1.
`timescale 1ns/1ps
module ocr_reader import ocr_pkg::*; #(
  parameter int BANKS = NUM_BANKS
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic cfg_ready_out,
  output logic [STA_W-1:0] station_hw_address_out,
  output logic [STA_W-1:0] radio_addr_out,
  output logic [ADC_W-1:0] adc_trim_out,
  output logic [XTL_W-1:0] xtal_trim_out,
  output logic [QG_W-1:0] quadrature_gain_trim_out,
  output logic [QP_W-1:0] quadrature_phase_trim_out,
  output logic [FV_W-1:0] field_valid_out,
  output logic quad_load_out
);
  if (BANKS != NUM_BANKS) begin : g_bad_banks
    $error("reader serves exactly the documented bank count");
  end

  // ****************************************
  // state
  // ****************************************
  ocr_state_t state;
  logic [5:0] widx;
  logic [5:0] ridx;
  logic rd_pend;
  logic [BANK_BITS-1:0] buf_bank;
  logic [BANK_BITS-1:0] next_buf;
  logic [BANK_BITS-1:0] sel;
  logic [2:0] act;
  logic found;
  logic [5:0] used_map;
  logic [5:0] inv_map;
  logic [5:0] prog_addr;
  logic raw_pend;
  logic [WORD_BITS-1:0] raw_data;
  logic ready_q;
  logic [SW_W-1:0] sw_bits;

  logic busy;
  logic wr_hit;
  logic rescan;
  logic raw_rd;
  logic burn;
  logic bank_end;

  ocr_fuse_if #(.AW(6), .DW(WORD_BITS)) fif ();

  // ****************************************
  // fuse array and bank decoder
  // ****************************************
  ocr_fuse_mem #(.WORDS(FUSE_WORDS), .WIDTH(WORD_BITS)) u_mem (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .fuse(fif.mem)
  );

  logic [STA_W-1:0] d_sta;
  logic [ADC_W-1:0] d_adc;
  logic [XTL_W-1:0] d_xtl;
  logic [QG_W-1:0] d_qg;
  logic [QP_W-1:0] d_qp;
  logic [SW_W-1:0] d_sw;
  logic [FV_W-1:0] d_vld;
  logic d_ok;

  ocr_bank_decode u_dec (
    .bank_in(sel),
    .sta_out(d_sta),
    .adc_out(d_adc),
    .xtl_out(d_xtl),
    .qg_out(d_qg),
    .qp_out(d_qp),
    .sw_out(d_sw),
    .valid_out(d_vld),
    .ok_out(d_ok)
  );

  // ****************************************
  // command decode
  // ****************************************
  // fuse port is shared, so software raw reads and burns are ignored until the scan is done
  assign busy = (state != OCR_DONE);
  assign wr_hit = reg_wr_in && (reg_addr_in == REG_CTRL);
  assign rescan = wr_hit && reg_wdata_in[CTRL_RESCAN];
  assign raw_rd = wr_hit && reg_wdata_in[CTRL_RAWRD] && !rescan && !busy;
  assign burn = reg_wr_in && (reg_addr_in == REG_PDATA) && !busy;
  assign bank_end = rd_pend && (ridx[2:0] == 3'(BANK_WORDS - 1));

  // fuse port drive
  assign fif.rd_en = (state == OCR_SCAN) || raw_rd;
  assign fif.addr = (state == OCR_SCAN) ? widx : prog_addr;
  assign fif.wr_en = burn;
  assign fif.wdata = reg_wdata_in[WORD_BITS-1:0];

  // ****************************************
  // scan sequencer
  // ****************************************
  // walk every word once, then one cycle to absorb the last read
  always_ff @(posedge mclk_in) begin
    if (reset_in || rescan) begin
      state <= OCR_SCAN;
      widx <= '0;
    end else begin
      unique case (state)
        OCR_SCAN: begin
          widx <= widx + 6'h01;
          if (widx == 6'(FUSE_WORDS - 1)) begin
            state <= OCR_DRAIN;
          end
        end
        OCR_DRAIN: begin
          state <= OCR_DONE;
        end
        OCR_DONE: begin
          state <= OCR_DONE;
        end
      endcase
    end
  end

  // read pipeline tracking
  always_ff @(posedge mclk_in) begin
    if (reset_in || rescan) begin
      rd_pend <= 1'b0;
      ridx <= '0;
    end else begin
      rd_pend <= (state == OCR_SCAN);
      ridx <= widx;
    end
  end

  // merge the arriving word into the bank being assembled
  always_comb begin
    next_buf = buf_bank;
    next_buf[ridx[2:0] * WORD_BITS +: WORD_BITS] = fif.rdata;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in || rescan) begin
      buf_bank <= '0;
    end else if (rd_pend) begin
      buf_bank <= next_buf;
    end
  end

  // ****************************************
  // bank selection
  // ****************************************
  // ascending walk: a later good bank overwrites an earlier one
  always_ff @(posedge mclk_in) begin
    if (reset_in || rescan) begin
      sel <= '0;
      act <= '0;
      found <= 1'b0;
    end else if (bank_end) begin
      if (ocr_bank_good(next_buf)) begin
        sel <= next_buf;
        act <= ridx[5:3];
        found <= 1'b1;
      end else if (ridx[5:3] == 3'h0) begin
        sel <= next_buf;
        act <= 3'h0;
      end
    end
  end

  // per-bank flag maps for software
  always_ff @(posedge mclk_in) begin
    if (reset_in || rescan) begin
      used_map <= '0;
      inv_map <= '0;
    end else if (bank_end) begin
      used_map[ridx[5:3]] <= next_buf[BANK_USED];
      inv_map[ridx[5:3]] <= next_buf[BANK_INV];
    end
  end

  // ****************************************
  // published parameters
  // ****************************************
  // fields without their flag read as zero so firmware skips them
  always_ff @(posedge mclk_in) begin
    if (reset_in || rescan) begin
      station_hw_address_out <= '0;
      radio_addr_out <= '0;
      adc_trim_out <= '0;
      xtal_trim_out <= '0;
      quadrature_gain_trim_out <= '0;
      quadrature_phase_trim_out <= '0;
      field_valid_out <= '0;
      sw_bits <= '0;
    end else begin
      station_hw_address_out <= d_vld[FV_STA] ? d_sta : '0;
      radio_addr_out <= d_vld[FV_STA] ? d_sta + 48'h1 : '0;
      adc_trim_out <= d_vld[1] ? d_adc : '0;
      xtal_trim_out <= d_vld[2] ? d_xtl : '0;
      quadrature_gain_trim_out <= d_vld[FV_QG] ? d_qg : '0;
      quadrature_phase_trim_out <= d_vld[FV_QP] ? d_qp : '0;
      field_valid_out <= d_vld;
      sw_bits <= d_ok ? d_sw : '0;
    end
  end

  // ready and the one-shot quadrature load
  always_ff @(posedge mclk_in) begin
    if (reset_in || rescan) begin
      ready_q <= 1'b0;
      quad_load_out <= 1'b0;
    end else begin
      ready_q <= (state == OCR_DONE);
      quad_load_out <= (state == OCR_DONE) && !ready_q
                       && d_vld[FV_QG] && d_vld[FV_QP];
    end
  end

  assign cfg_ready_out = ready_q;

  // ****************************************
  // software fuse access
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      prog_addr <= '0;
    end else if (reg_wr_in && reg_addr_in == REG_PADDR) begin
      prog_addr <= reg_wdata_in[5:0];
    end
  end

  // raw word snapshot, one cycle after the read command
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      raw_pend <= 1'b0;
      raw_data <= '0;
    end else begin
      raw_pend <= raw_rd;
      if (raw_pend) begin
        raw_data <= fif.rdata;
      end
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  function automatic logic [31:0] rd_mux(input logic [3:0] a);
    logic [31:0] v;
    v = RDATA_IDLE;
    unique case (a)
      REG_STATUS: begin
        v[ST_READY] = ready_q;
        v[ST_FOUND] = found;
        v[ST_ACT_LSB +: 3] = act;
        v[ST_USED_LSB +: 6] = used_map;
        v[ST_INV_LSB +: 6] = inv_map;
        v[ST_BUSY] = busy;
      end
      REG_STA_LO: v = station_hw_address_out[31:0];
      REG_STA_HI: v[15:0] = station_hw_address_out[47:32];
      REG_RAD_LO: v = radio_addr_out[31:0];
      REG_RAD_HI: v[15:0] = radio_addr_out[47:32];
      REG_ADC: v[ADC_W-1:0] = adc_trim_out;
      REG_XTL: v[XTL_W-1:0] = xtal_trim_out;
      REG_QG: v[QG_W-1:0] = quadrature_gain_trim_out;
      REG_QP: v[QP_W-1:0] = quadrature_phase_trim_out;
      REG_VALID: v[FV_W-1:0] = field_valid_out;
      REG_PADDR: v[5:0] = prog_addr;
      REG_PDATA: v[WORD_BITS-1:0] = raw_data;
      REG_SW: v[SW_W-1:0] = sw_bits;
      default: v = RDATA_IDLE;
    endcase
    return v;
  endfunction

  // data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      reg_rdata_out <= RDATA_IDLE;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux(reg_addr_in);
    end else begin
      reg_rdata_out <= RDATA_IDLE;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  logic [5:0] good_mask;
  assign good_mask = used_map & ~inv_map;

  sequence drain_s;
    state == OCR_DRAIN && !rescan;
  endsequence

  sequence done_s;
    state == OCR_DONE ##1 (ready_q || state == OCR_SCAN);
  endsequence

  scan_finish_a: assert property (drain_s |=> done_s)
    else $error("scan did not finish after drain");

  scan_length_a: assert property (
    (state == OCR_SCAN && widx == 6'h2F && !rescan) |=> state == OCR_DRAIN)
    else $error("scan did not cover all words");

  radio_plus_a: assert property (
    field_valid_out[FV_STA] |-> radio_addr_out == station_hw_address_out + 48'h1)
    else $error("radio address not station plus one");

  invalid_gate_a: assert property (
    (ready_q && sel[BANK_INV]) |-> field_valid_out == '0)
    else $error("invalid bank supplied a field");

  used_gate_a: assert property (
    (ready_q && !sel[BANK_USED]) |-> field_valid_out == '0)
    else $error("unused bank supplied a field");

  flag_map_a: assert property (
    ready_q |-> field_valid_out[FV_STA] == (sel[STA_VLD] && ocr_bank_good(sel)))
    else $error("station flag not honoured");

  quad_load_a: assert property (
    ($rose(ready_q) && field_valid_out[FV_QG] && field_valid_out[FV_QP])
      |-> quad_load_out)
    else $error("quadrature load missing");

  quad_skip_a: assert property (
    (ready_q && !field_valid_out[FV_QG]) |-> quadrature_gain_trim_out == '0
      && !quad_load_out)
    else $error("unflagged quadrature gain used");

  highest_bank_a: assert property (
    (ready_q && found) |-> (good_mask >> act) == 6'h01)
    else $error("active bank is not the highest good bank");

  fallback_a: assert property (
    (ready_q && !found) |-> act == 3'h0)
    else $error("fallback bank is not zero");
endmodule

/* File: pkg/ocr_fuse_if.sv */
// Purpose: port bundle between the reader and the fuse array
// Assumes: read data one cycle after the read enable
// Notes: writes only ever set bits
`timescale 1ns/1ps
interface ocr_fuse_if #(parameter int AW = 6, parameter int DW = 16);
  logic rd_en;
  logic wr_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctl (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

/* File: pkg/ocr_pkg.sv */
// Purpose: shared constants and types of the fuse bank reader
// Assumes: fuse words of 16 bits, eight words to a bank
// Notes: bank field positions are implementation choices
package ocr_pkg;
  // ****************************************
  // fuse store geometry
  // ****************************************
  localparam int FUSE_BITS = 768;
  localparam int NUM_BANKS = 6;
  localparam int BANK_BITS = 128;
  localparam int FIXED_BITS = 108;
  localparam int WORD_BITS = 16;
  localparam int BANK_WORDS = BANK_BITS / WORD_BITS;
  localparam int FUSE_WORDS = FUSE_BITS / WORD_BITS;
  // ****************************************
  // field layout inside one bank
  // ****************************************
  localparam int STA_LSB = 0;
  localparam int STA_W = 48;
  localparam int STA_VLD = 48;
  localparam int ADC_LSB = 49;
  localparam int ADC_W = 12;
  localparam int ADC_VLD = 61;
  localparam int XTL_LSB = 62;
  localparam int XTL_W = 15;
  localparam int XTL_VLD = 77;
  localparam int QG_LSB = 78;
  localparam int QG_W = 10;
  localparam int QG_VLD = 88;
  localparam int QP_LSB = 89;
  localparam int QP_W = 10;
  localparam int QP_VLD = 99;
  localparam int BANK_INV = 106;
  localparam int BANK_USED = 107;
  localparam int SW_LSB = FIXED_BITS;
  localparam int SW_W = BANK_BITS - FIXED_BITS;
  // field valid vector order
  localparam int FV_STA = 0;
  localparam int FV_QG = 3;
  localparam int FV_QP = 4;
  localparam int FV_W = 5;
  // ****************************************
  // register word indices and fields
  // ****************************************
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_STA_LO = 4'h2;
  localparam logic [3:0] REG_STA_HI = 4'h3;
  localparam logic [3:0] REG_RAD_LO = 4'h4;
  localparam logic [3:0] REG_RAD_HI = 4'h5;
  localparam logic [3:0] REG_ADC = 4'h6;
  localparam logic [3:0] REG_XTL = 4'h7;
  localparam logic [3:0] REG_QG = 4'h8;
  localparam logic [3:0] REG_QP = 4'h9;
  localparam logic [3:0] REG_VALID = 4'hA;
  localparam logic [3:0] REG_PADDR = 4'hB;
  localparam logic [3:0] REG_PDATA = 4'hC;
  localparam logic [3:0] REG_SW = 4'hD;
  localparam int CTRL_RESCAN = 0;
  localparam int CTRL_RAWRD = 1;
  localparam int ST_READY = 0;
  localparam int ST_FOUND = 1;
  localparam int ST_ACT_LSB = 2;
  localparam int ST_USED_LSB = 6;
  localparam int ST_INV_LSB = 12;
  localparam int ST_BUSY = 18;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  typedef enum logic [1:0] {OCR_SCAN, OCR_DRAIN, OCR_DONE} ocr_state_t;

  // a bank supplies data only when used and not invalidated
  function automatic logic ocr_bank_good(input logic [BANK_BITS-1:0] b);
    return b[BANK_USED] & ~b[BANK_INV];
  endfunction
endpackage

/* File: test/ocr_prog_model.sv */
// Purpose: fuse programmer and firmware side of the register port
// Assumes: every request is driven just after a rising clock edge
// Notes: idle write data is inverted so a stale value never looks valid
`timescale 1ns/1ps
module ocr_prog_model import ocr_pkg::*; (
  input wire logic mclk_in,
  input wire logic [31:0] reg_rdata_in,
  output logic [3:0] reg_addr_out,
  output logic [31:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out
);
  // ****************************************
  // register port master
  // ****************************************
  // quiet bus at time zero
  initial begin
    reg_addr_out = 4'h0;
    reg_wdata_out = 32'h0000_0000;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge mclk_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d; // released data must not hold its value
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge mclk_in);
    reg_rd_out <= 1'b0;
    #1;
    d = reg_rdata_in;
  endtask

  // ****************************************
  // fuse programming steps
  // ****************************************
  task automatic burn(input int w, input logic [15:0] bits);
    wr_reg(REG_PADDR, 32'(w));
    wr_reg(REG_PDATA, {16'h0000, bits});
  endtask

  // body first, used flag last, so a half-written bank is never picked
  task automatic program_bank(input int b, input logic [BANK_BITS-1:0] img);
    logic [BANK_BITS-1:0] body;
    body = img;
    body[BANK_USED] = 1'b0;
    for (int w = 0; w < BANK_WORDS; w++) begin
      if (body[w*WORD_BITS +: WORD_BITS] != 16'h0000) begin
        burn(b*BANK_WORDS+w, body[w*WORD_BITS +: WORD_BITS]);
      end
    end
    if (img[BANK_USED]) begin
      burn(b*BANK_WORDS+BANK_USED/WORD_BITS, 16'(1) << (BANK_USED%WORD_BITS));
    end
  endtask

  task automatic invalidate(input int b);
    burn(b*BANK_WORDS+BANK_INV/WORD_BITS, 16'(1) << (BANK_INV%WORD_BITS));
  endtask
endmodule

/* File: test/otp_bank_config_reader_tb.sv */
// Purpose: self-checking bench of the fuse bank reader
// Assumes: fuses start blank and are loaded only by burns
// Notes: scan length is checked to the cycle from the fuse word count
`timescale 1ns/1ps
module otp_bank_config_reader_tb import ocr_pkg::*; ;
  logic mclk, rst, wr, rd, ready, qload;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [STA_W-1:0] sta, radio;
  logic [ADC_W-1:0] adc;
  logic [XTL_W-1:0] xtl;
  logic [QG_W-1:0] qg;
  logic [QP_W-1:0] qp;
  logic [FV_W-1:0] fv;
  int errors, n_checks, cyc;

  ocr_reader #(.BANKS(NUM_BANKS)) u_dut (.mclk_in(mclk), .reset_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .cfg_ready_out(ready), .station_hw_address_out(sta),
    .radio_addr_out(radio), .adc_trim_out(adc), .xtal_trim_out(xtl),
    .quadrature_gain_trim_out(qg), .quadrature_phase_trim_out(qp),
    .field_valid_out(fv), .quad_load_out(qload));
  ocr_prog_model u_prog (.mclk_in(mclk), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));

  // ****************************************
  // clock, timeout and report
  // ****************************************
  // 250 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // the whole run needs about 400 cycles; a hang ends here
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rchk(input string name, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_prog.rd_reg(a, d);
    chk(name, 48'(exp), 48'(d));
  endtask

  // ****************************************
  // expected values
  // ****************************************
  // trims are the same in every bank, as copies are carried along
  function automatic logic [BANK_BITS-1:0] mk(input logic [47:0] s, input logic [4:0] f,
      input logic [19:0] sw);
    logic [BANK_BITS-1:0] b;
    b = '0;
    b[STA_LSB +: STA_W] = s;
    b[ADC_LSB +: ADC_W] = 12'hABC;
    b[XTL_LSB +: XTL_W] = 15'h5A5A;
    b[QG_LSB +: QG_W] = 10'h2C3;
    b[QP_LSB +: QP_W] = 10'h1F0;
    b[STA_VLD] = f[0];
    b[ADC_VLD] = f[1];
    b[XTL_VLD] = f[2];
    b[QG_VLD] = f[3];
    b[QP_VLD] = f[4];
    b[SW_LSB +: SW_W] = sw;
    b[BANK_USED] = 1'b1;
    return b;
  endfunction

  function automatic logic [31:0] st(input logic found, input logic [2:0] act,
      input logic [5:0] used, input logic [5:0] inv);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[ST_READY] = 1'b1;
    s[ST_FOUND] = found;
    s[ST_ACT_LSB +: 3] = act;
    s[ST_USED_LSB +: 6] = used;
    s[ST_INV_LSB +: 6] = inv;
    return s;
  endfunction

  // ****************************************
  // scan and output checks
  // ****************************************
  // exp_n: words read, one drain and one done cycle, less any cycle already waited
  task automatic wait_ready(input logic exp_q, input int exp_n);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 60) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("scan_len", 48'(exp_n), 48'(n));
    chk("quad_load", 48'(exp_q), 48'(qload));
  endtask

  task automatic rescan(input logic exp_q);
    u_prog.wr_reg(REG_CTRL, 32'h0000_0001);
    @(posedge mclk);
    #1;
    chk("ready_drop", 48'h0, 48'(ready));
    wait_ready(exp_q, FUSE_WORDS + 1);
  endtask

  task automatic chk_out(input logic [BANK_BITS-1:0] img, input logic [FV_W-1:0] f);
    chk("field_valid", 48'(f), 48'(fv));
    chk("station", f[0] ? img[STA_LSB +: STA_W] : 48'h0, sta);
    chk("radio", f[0] ? img[STA_LSB +: STA_W] + 48'h1 : 48'h0, radio);
    chk("adc", f[1] ? 48'(img[ADC_LSB +: ADC_W]) : 48'h0, 48'(adc));
    chk("xtal", f[2] ? 48'(img[XTL_LSB +: XTL_W]) : 48'h0, 48'(xtl));
    chk("qgain", f[3] ? 48'(img[QG_LSB +: QG_W]) : 48'h0, 48'(qg));
    chk("qphase", f[4] ? 48'(img[QP_LSB +: QP_W]) : 48'h0, 48'(qp));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [BANK_BITS-1:0] b0, b1, b5;
    errors = 0;
    n_checks = 0;
    rst = 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    wait_ready(1'b0, FUSE_WORDS + 2);
    chk_out('0, 5'h00);
    rchk("status", REG_STATUS, st(1'b0, 3'd0, 6'h00, 6'h00));
    rchk("unmapped", 4'hE, 32'h0000_0000);
    // bank 0 with all fields; address carries across the 32-bit split
    b0 = mk(48'h00A1_FFFF_FFFF, 5'h1F, 20'hABCDE);
    u_prog.program_bank(0, b0);
    u_prog.wr_reg(REG_PADDR, 32'h0000_0006);
    u_prog.wr_reg(REG_CTRL, 32'h0000_0002);
    rchk("raw_word", REG_PDATA, {16'h0000, b0[6*WORD_BITS +: WORD_BITS]});
    rescan(1'b1);
    chk_out(b0, 5'h1F);
    rchk("radio_hi", REG_RAD_HI, 32'h0000_00A2);
    rchk("radio_lo", REG_RAD_LO, 32'h0000_0000);
    rchk("sw_bits", REG_SW, 32'h000A_BCDE);
    rchk("status", REG_STATUS, st(1'b1, 3'd0, 6'h01, 6'h00));
    // address change; address wraps to zero, xtal and qgain flags clear
    u_prog.invalidate(0);
    b1 = mk(48'hFFFF_FFFF_FFFF, 5'h13, 20'h00000);
    u_prog.program_bank(1, b1);
    rescan(1'b0);
    chk_out(b1, 5'h13);
    rchk("status", REG_STATUS, st(1'b1, 3'd1, 6'h03, 6'h01));
    // a higher bank that is used but invalid must not win
    b5 = mk(48'h0000_5555_0000, 5'h1F, 20'h00000);
    u_prog.program_bank(5, b5);
    u_prog.invalidate(5);
    rescan(1'b0);
    chk_out(b1, 5'h13);
    rchk("status", REG_STATUS, st(1'b1, 3'd1, 6'h23, 6'h21));
    // second reset mid-run: fuses survive, outputs clear, scan repeats
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("reset_ready", 48'h0, 48'(ready));
    chk("reset_station", 48'h0, sta);
    @(posedge mclk);
    rst <= 1'b0;
    wait_ready(1'b0, FUSE_WORDS + 2);
    chk_out(b1, 5'h13);
    wrap_up();
  end
endmodule
